/* File: rtl/ipfd_pkg.sv */
/*
 priority field decode package: register indices and byte addresses,
 field positions, reset values, write masks and the priority encoding.
 assumes a 32-bit ahb-lite slave with registers on aligned words.
*/
`default_nettype none
package ipfd_pkg;
  // printed offsets are word indices, byte address is four times each
  localparam int unsigned IPFD_REG_THREE_IDX = 3;
  localparam int unsigned IPFD_REG_FOUR_IDX = 4;
  localparam logic [7:0] IPFD_REG_THREE_ADDR = 8'(IPFD_REG_THREE_IDX * 4);
  localparam logic [7:0] IPFD_REG_FOUR_ADDR = 8'(IPFD_REG_FOUR_IDX * 4);
  localparam int unsigned IPFD_REG_W = 16;

  localparam logic [15:0] IPFD_REG_THREE_RST = 16'h0000;
  localparam logic [15:0] IPFD_REG_FOUR_RST = 16'h0000;
  // reserved spans are not writable and read as zero
  localparam logic [15:0] IPFD_REG_THREE_MASK = 16'hf0ff;
  localparam logic [15:0] IPFD_REG_FOUR_MASK = 16'hf00f;

  // request sources, index into the request and forward vectors
  localparam int unsigned IPFD_NSRC = 10;
  localparam int unsigned IPFD_SRC_DMA3 = 0;
  localparam int unsigned IPFD_SRC_DMA2 = 1;
  localparam int unsigned IPFD_SRC_DMA1 = 2;
  localparam int unsigned IPFD_SRC_DMA0 = 3;
  localparam int unsigned IPFD_SRC_CAN_ERR = 4;
  localparam int unsigned IPFD_SRC_CAN_TXW = 5;
  localparam int unsigned IPFD_SRC_CAN_RXW = 6;
  localparam int unsigned IPFD_SRC_CAN_WAKE = 7;
  localparam int unsigned IPFD_SRC_SER1_RXE = 8;
  localparam int unsigned IPFD_SRC_SER1_RXF = 9;
  // field low bit of each source inside its register
  localparam int unsigned IPFD_SRC_LSB [IPFD_NSRC] = '{0, 2, 4, 6, 12, 14, 0, 2, 12, 14};
  // set where the source's field lives in register four
  localparam logic [IPFD_NSRC-1:0] IPFD_SRC_IN_FOUR = 10'h3c0;

  typedef enum logic [1:0] {
    IPFD_PRIO_OFF = 2'h0,
    IPFD_PRIO_L0 = 2'h1,
    IPFD_PRIO_L1 = 2'h2,
    IPFD_PRIO_L2 = 2'h3
  } ipfd_prio_t;

  localparam int unsigned IPFD_NLVL = 3;
endpackage
`default_nettype wire

/* File: rtl/ipfd_top.sv */
/*
 priority register pair (three and four) with per-source decode into
 three core priority levels, reached over ahb-lite.
 assumes peripheral request lines are levels on hclk, single word transfers.
*/
// The AHB-Lite register port was chosen for this implementation.
`default_nettype none
// What this block does
// - field codes off, level zero, one, two
// - requests reach only levels zero to two
// - all fields reset to disabled
// - register four bits 15:14 serial1 rx full
// - register four bits 13:12 serial1 rx error
// - register four bits 11:4 reserved
// - register four bits 3:2 bus wakeup
// - register four holds bus rx warning field
// - register three holds dma channel 3 field
// - register three bits 3:2 dma channel 2
module ipfd_top
  import ipfd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [IPFD_NSRC-1:0] periph_req,
  output logic [IPFD_NSRC-1:0] fwd_req,
  output logic [IPFD_NLVL-1:0] core_lvl_req,
  output logic core_irq_valid,
  output logic [1:0] core_irq_level
);

  function automatic logic [IPFD_NLVL-1:0] prio_onehot(input logic [1:0] f);
    case (f)
      IPFD_PRIO_L0: prio_onehot = 3'h1;
      IPFD_PRIO_L1: prio_onehot = 3'h2;
      IPFD_PRIO_L2: prio_onehot = 3'h4;
      default: prio_onehot = 3'h0;
    endcase
  endfunction

  logic [15:0] ipr3_q, ipr3_d;
  logic [15:0] ipr4_q, ipr4_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic acc;
  logic [IPFD_NSRC-1:0] fwd_q, fwd_d;
  logic [IPFD_NLVL-1:0] lvl_q, lvl_d;
  logic valid_q, valid_d;
  logic [1:0] level_q, level_d;
  logic [IPFD_NLVL-1:0] hit [IPFD_NSRC];
  logic hsize_unused;

  // zero wait state, always okay; size is assumed to be a full word
  assign acc = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign hsize_unused = ^hsize;

  always_comb begin
    ipr3_d = ipr3_q;
    ipr4_d = ipr4_q;
    // write lands in the data phase; reserved bits are masked off
    if (wr_pend_q && wr_addr_q == IPFD_REG_THREE_ADDR) begin
      ipr3_d = hwdata[15:0] & IPFD_REG_THREE_MASK;
    end
    if (wr_pend_q && wr_addr_q == IPFD_REG_FOUR_ADDR) begin
      ipr4_d = hwdata[15:0] & IPFD_REG_FOUR_MASK;
    end
    wr_pend_d = acc && hwrite;
    wr_addr_d = acc ? haddr[7:0] : wr_addr_q;
    // read sampled from next values so a write just before is seen
    rdata_d = 32'h0000_0000;
    if (acc && !hwrite) begin
      if (haddr[7:0] == IPFD_REG_THREE_ADDR) begin
        rdata_d = {16'h0000, ipr3_d};
      end else if (haddr[7:0] == IPFD_REG_FOUR_ADDR) begin
        rdata_d = {16'h0000, ipr4_d};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ipr3_q <= IPFD_REG_THREE_RST;
      ipr4_q <= IPFD_REG_FOUR_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      ipr3_q <= ipr3_d;
      ipr4_q <= ipr4_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // per-source decode of its field into a one-hot level
  generate
    for (genvar i = 0; i < IPFD_NSRC; i++) begin : g_src
      logic [1:0] fld;
      assign fld = IPFD_SRC_IN_FOUR[i] ? ipr4_q[IPFD_SRC_LSB[i] +: 2] : ipr3_q[IPFD_SRC_LSB[i] +: 2];
      assign hit[i] = periph_req[i] ? prio_onehot(fld) : 3'h0;
    end
  endgenerate

  always_comb begin
    lvl_d = 3'h0;
    fwd_d = '0;
    for (int i = 0; i < IPFD_NSRC; i++) begin
      lvl_d = lvl_d | hit[i];
      fwd_d[i] = |hit[i];
    end
    valid_d = |lvl_d;
    // highest level wins; no encoding above level two exists
    if (lvl_d[2]) begin
      level_d = 2'h2;
    end else if (lvl_d[1]) begin
      level_d = 2'h1;
    end else begin
      level_d = 2'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_q <= '0;
      lvl_q <= 3'h0;
      valid_q <= 1'b0;
      level_q <= 2'h0;
    end else begin
      fwd_q <= fwd_d;
      lvl_q <= lvl_d;
      valid_q <= valid_d;
      level_q <= level_d;
    end
  end

  assign fwd_req = fwd_q;
  assign core_lvl_req = lvl_q;
  assign core_irq_valid = valid_q;
  assign core_irq_level = level_q;

  // checks
  logic first_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr4;
    acc && hwrite && haddr[7:0] == IPFD_REG_FOUR_ADDR ##1 1'b1;
  endsequence
  sequence s_wr3;
    acc && hwrite && haddr[7:0] == IPFD_REG_THREE_ADDR ##1 1'b1;
  endsequence

  a_reset_fields_off: assert property (first_q
    |-> ipr3_q == 16'h0000 && ipr4_q == 16'h0000 && fwd_q == '0)
    else $error("fields not disabled after reset");
  a_ser1_rxf_field: assert property (s_wr4 |=> ipr4_q[15:14] == $past(hwdata[15:14]))
    else $error("serial1 rx full field not written");
  a_ser1_rxe_field: assert property (s_wr4 |=> ipr4_q[13:12] == $past(hwdata[13:12]))
    else $error("serial1 rx error field not written");
  a_four_reserved: assert property (ipr4_q[11:4] == 8'h00 && (!valid_q || level_q != 2'h3))
    else $error("reserved bits of register four set");
  a_wake_field: assert property (s_wr4 |=> ipr4_q[3:2] == $past(hwdata[3:2]))
    else $error("wakeup field not written");
  a_rxw_field: assert property (s_wr4 |=> ipr4_q[1:0] == $past(hwdata[1:0]))
    else $error("rx warning field not written");
  a_dma3_field: assert property (s_wr3 |=> ipr3_q[1:0] == $past(hwdata[1:0]))
    else $error("dma3 field not written");
  a_dma2_field: assert property (s_wr3 |=> ipr3_q[3:2] == $past(hwdata[3:2]))
    else $error("dma2 field not written");
  a_rxw_drives_level: assert property (periph_req[IPFD_SRC_CAN_RXW] && ipr4_q[1:0] == 2'h2 |=> lvl_q[1])
    else $error("rx warning at bits 1:0 not decoded");
  a_decode_top_level: assert property (periph_req[IPFD_SRC_SER1_RXF] && ipr4_q[15:14] == 2'h3
    |=> lvl_q[2] && level_q == 2'h2)
    else $error("level two not presented");
  // several levels may be pending at once; the reported one must be the highest
  a_level_cap: assert property (valid_q |-> level_q != 2'h3 && (lvl_q >> level_q) == 3'h1)
    else $error("level above two presented");
  a_disabled_blocked: assert property (ipr3_q[1:0] == 2'h0 |=> !fwd_q[IPFD_SRC_DMA3])
    else $error("disabled dma3 forwarded");
  a_read_back: assert property (acc && !hwrite && haddr[7:0] == IPFD_REG_FOUR_ADDR |=> hrdata == {16'h0000, ipr4_q})
    else $error("read data mismatch");
  a_read_three: assert property (acc && !hwrite && haddr[7:0] == IPFD_REG_THREE_ADDR
    |=> hrdata == {16'h0000, ipr3_q})
    else $error("register three read data mismatch");
  a_read_idle_zero: assert property (!(acc && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data not cleared outside data phase");
  a_unmapped_dropped: assert property (acc && hwrite && haddr[7:0] != IPFD_REG_THREE_ADDR
    && haddr[7:0] != IPFD_REG_FOUR_ADDR ##1 1'b1 |=> $stable(ipr3_q) && $stable(ipr4_q))
    else $error("unmapped write changed a register");
  a_three_reserved: assert property (ipr3_q[11:8] == 4'h0)
    else $error("reserved bits of register three set");
  a_idle_quiet: assert property (!valid_q |-> lvl_q == 3'h0 && level_q == 2'h0 && fwd_q == '0)
    else $error("request shown without valid");
  a_no_req_no_fwd: assert property (periph_req == '0 |=> fwd_q == '0 && !valid_q)
    else $error("request forwarded with no line raised");

  // a disabled field blocks its source, whatever the request line does
  a_dma2_gated: assert property (ipr3_q[3:2] == 2'h0 |=> !fwd_q[IPFD_SRC_DMA2])
    else $error("disabled dma2 forwarded");
  a_dma1_gated: assert property (ipr3_q[5:4] == 2'h0 |=> !fwd_q[IPFD_SRC_DMA1])
    else $error("disabled dma1 forwarded");
  a_dma0_gated: assert property (ipr3_q[7:6] == 2'h0 |=> !fwd_q[IPFD_SRC_DMA0])
    else $error("disabled dma0 forwarded");
  a_cerr_gated: assert property (ipr3_q[13:12] == 2'h0 |=> !fwd_q[IPFD_SRC_CAN_ERR])
    else $error("disabled bus error forwarded");
  a_ctxw_gated: assert property (ipr3_q[15:14] == 2'h0 |=> !fwd_q[IPFD_SRC_CAN_TXW])
    else $error("disabled bus tx warning forwarded");
  a_rxw_gated: assert property (ipr4_q[1:0] == 2'h0 |=> !fwd_q[IPFD_SRC_CAN_RXW])
    else $error("disabled bus rx warning forwarded");
  a_wake_gated: assert property (ipr4_q[3:2] == 2'h0 |=> !fwd_q[IPFD_SRC_CAN_WAKE])
    else $error("disabled wakeup forwarded");
  a_rxe_gated: assert property (ipr4_q[13:12] == 2'h0 |=> !fwd_q[IPFD_SRC_SER1_RXE])
    else $error("disabled serial1 rx error forwarded");
  a_rxf_gated: assert property (ipr4_q[15:14] == 2'h0 |=> !fwd_q[IPFD_SRC_SER1_RXF])
    else $error("disabled serial1 rx full forwarded");

  // code 11 of each field lands on the top level
  a_dma3_lvl_two: assert property (periph_req[IPFD_SRC_DMA3] && ipr3_q[1:0] == 2'h3
    |=> fwd_q[IPFD_SRC_DMA3] && lvl_q[2])
    else $error("dma3 level two not presented");
  a_dma2_lvl_two: assert property (periph_req[IPFD_SRC_DMA2] && ipr3_q[3:2] == 2'h3
    |=> fwd_q[IPFD_SRC_DMA2] && lvl_q[2])
    else $error("dma2 level two not presented");
  a_dma1_lvl_two: assert property (periph_req[IPFD_SRC_DMA1] && ipr3_q[5:4] == 2'h3
    |=> fwd_q[IPFD_SRC_DMA1] && lvl_q[2])
    else $error("dma1 level two not presented");
  a_dma0_lvl_two: assert property (periph_req[IPFD_SRC_DMA0] && ipr3_q[7:6] == 2'h3
    |=> fwd_q[IPFD_SRC_DMA0] && lvl_q[2])
    else $error("dma0 level two not presented");
  a_cerr_lvl_two: assert property (periph_req[IPFD_SRC_CAN_ERR] && ipr3_q[13:12] == 2'h3
    |=> fwd_q[IPFD_SRC_CAN_ERR] && lvl_q[2])
    else $error("bus error level two not presented");
  a_ctxw_lvl_two: assert property (periph_req[IPFD_SRC_CAN_TXW] && ipr3_q[15:14] == 2'h3
    |=> fwd_q[IPFD_SRC_CAN_TXW] && lvl_q[2])
    else $error("bus tx warning level two not presented");
  a_rxw_lvl_two: assert property (periph_req[IPFD_SRC_CAN_RXW] && ipr4_q[1:0] == 2'h3
    |=> fwd_q[IPFD_SRC_CAN_RXW] && lvl_q[2])
    else $error("bus rx warning level two not presented");
  a_wake_lvl_two: assert property (periph_req[IPFD_SRC_CAN_WAKE] && ipr4_q[3:2] == 2'h3
    |=> fwd_q[IPFD_SRC_CAN_WAKE] && lvl_q[2])
    else $error("wakeup level two not presented");
  a_rxe_lvl_two: assert property (periph_req[IPFD_SRC_SER1_RXE] && ipr4_q[13:12] == 2'h3
    |=> fwd_q[IPFD_SRC_SER1_RXE] && lvl_q[2])
    else $error("serial1 rx error level two not presented");

  // code 10 of a field lands on the middle level
  a_dma2_lvl_one: assert property (periph_req[IPFD_SRC_DMA2] && ipr3_q[3:2] == 2'h2
    |=> fwd_q[IPFD_SRC_DMA2] && lvl_q[1])
    else $error("dma2 level one not presented");
  a_dma1_lvl_one: assert property (periph_req[IPFD_SRC_DMA1] && ipr3_q[5:4] == 2'h2
    |=> fwd_q[IPFD_SRC_DMA1] && lvl_q[1])
    else $error("dma1 level one not presented");
  a_dma0_lvl_one: assert property (periph_req[IPFD_SRC_DMA0] && ipr3_q[7:6] == 2'h2
    |=> fwd_q[IPFD_SRC_DMA0] && lvl_q[1])
    else $error("dma0 level one not presented");

  // code 01 of each field lands on the bottom level
  a_dma3_lvl_zero: assert property (periph_req[IPFD_SRC_DMA3] && ipr3_q[1:0] == 2'h1
    |=> fwd_q[IPFD_SRC_DMA3] && lvl_q[0])
    else $error("dma3 level zero not presented");
  a_dma2_lvl_zero: assert property (periph_req[IPFD_SRC_DMA2] && ipr3_q[3:2] == 2'h1
    |=> fwd_q[IPFD_SRC_DMA2] && lvl_q[0])
    else $error("dma2 level zero not presented");
  a_dma1_lvl_zero: assert property (periph_req[IPFD_SRC_DMA1] && ipr3_q[5:4] == 2'h1
    |=> fwd_q[IPFD_SRC_DMA1] && lvl_q[0])
    else $error("dma1 level zero not presented");
  a_dma0_lvl_zero: assert property (periph_req[IPFD_SRC_DMA0] && ipr3_q[7:6] == 2'h1
    |=> fwd_q[IPFD_SRC_DMA0] && lvl_q[0])
    else $error("dma0 level zero not presented");
  a_cerr_lvl_zero: assert property (periph_req[IPFD_SRC_CAN_ERR] && ipr3_q[13:12] == 2'h1
    |=> fwd_q[IPFD_SRC_CAN_ERR] && lvl_q[0])
    else $error("bus error level zero not presented");
  a_ctxw_lvl_zero: assert property (periph_req[IPFD_SRC_CAN_TXW] && ipr3_q[15:14] == 2'h1
    |=> fwd_q[IPFD_SRC_CAN_TXW] && lvl_q[0])
    else $error("bus tx warning level zero not presented");
  a_rxw_lvl_zero: assert property (periph_req[IPFD_SRC_CAN_RXW] && ipr4_q[1:0] == 2'h1
    |=> fwd_q[IPFD_SRC_CAN_RXW] && lvl_q[0])
    else $error("bus rx warning level zero not presented");
  a_wake_lvl_zero: assert property (periph_req[IPFD_SRC_CAN_WAKE] && ipr4_q[3:2] == 2'h1
    |=> fwd_q[IPFD_SRC_CAN_WAKE] && lvl_q[0])
    else $error("wakeup level zero not presented");
  a_rxe_lvl_zero: assert property (periph_req[IPFD_SRC_SER1_RXE] && ipr4_q[13:12] == 2'h1
    |=> fwd_q[IPFD_SRC_SER1_RXE] && lvl_q[0])
    else $error("serial1 rx error level zero not presented");
  a_rxf_lvl_zero: assert property (periph_req[IPFD_SRC_SER1_RXF] && ipr4_q[15:14] == 2'h1
    |=> fwd_q[IPFD_SRC_SER1_RXF] && lvl_q[0])
    else $error("serial1 rx full level zero not presented");

  c_write_then_fwd: cover property (s_wr3 ##1 periph_req[IPFD_SRC_DMA3] ##1 fwd_q[IPFD_SRC_DMA3]);
  c_level_two: cover property (core_irq_valid && core_irq_level == 2'h2);
  c_read_four: cover property (acc && !hwrite && haddr[7:0] == IPFD_REG_FOUR_ADDR ##1 hrdata != 32'h0);
  c_all_levels: cover property (lvl_q == 3'h7);
  c_level_zero: cover property (core_irq_valid && core_irq_level == 2'h0);

endmodule // ipfd_top
`default_nettype wire

/* File: verification/ipfd_core_model.sv */
/*
 processor core stand-in: takes the prioritised request it sees each cycle.
 assumes the request outputs are registered on hclk.
*/
`default_nettype none
module ipfd_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic core_irq_valid,
  input wire logic [1:0] core_irq_level,
  output logic [1:0] taken_level_q,
  output logic [7:0] taken_cnt_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // no acknowledge goes back: the block latches nothing, each peripheral holds its own request level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taken_level_q <= 2'h0;
      taken_cnt_q <= 8'h0;
    end else if (core_irq_valid) begin
      taken_level_q <= core_irq_level;
      taken_cnt_q <= taken_cnt_q + 8'h1;
    end
  end
endmodule // ipfd_core_model
`default_nettype wire

/* File: verification/irq_priority_field_decode_tb_top.sv */
/*
 bench for the priority field decode block: ahb-lite master, request driver, queued checks.
 assumes hready is tied to hreadyout and a 20 mhz hclk.
*/
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module irq_priority_field_decode_tb_top;
  import ipfd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, rd_ph, ck_ph, hreadyout, hresp, core_irq_valid;
  logic [1:0] htrans, core_irq_level;
  logic [2:0] hsize, core_lvl_req;
  logic [31:0] haddr, hwdata, hrdata, er;
  logic [9:0] periph_req, fwd_req;
  logic [15:0] r3, r4, ep;
  logic [31:0] rq[$];
  logic [15:0] pq[$];
  int mismatches, n_tests;
  int unsigned lsb [10] = '{0, 2, 4, 6, 12, 14, 0, 2, 12, 14};
  ipfd_top dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .periph_req, .fwd_req, .core_lvl_req, .core_irq_valid, .core_irq_level);
  ipfd_core_model core(.hclk, .hresetn, .core_irq_valid, .core_irq_level, .taken_level_q(), .taken_cnt_q());
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task close_out;
    $display("mismatches %0d checks %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      close_out;
    end
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
    logic [31:0] w;
    w = {16'($urandom), d};
    if (!wr) rq.push_back({16'h0, a == IPFD_REG_THREE_ADDR ? r3 : a == IPFD_REG_FOUR_ADDR ? r4 : 16'h0});
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w;
    rd_ph <= !wr;
    wait_rdy;
    rd_ph <= 1'b0;
    // reserved spans never take written ones
    if (wr && a == IPFD_REG_THREE_ADDR) r3 = d & 16'hf0ff;
    if (wr && a == IPFD_REG_FOUR_ADDR) r4 = d & 16'hf00f;
  endtask
  function automatic logic [15:0] expo(input logic [9:0] v);
    logic [9:0] f;
    logic [2:0] l;
    logic [1:0] c;
    f = '0;
    l = '0;
    for (int i = 0; i < 10; i++) begin
      c = 2'((i > 5 ? r4 : r3) >> lsb[i]);
      f[i] = v[i] && c != 2'h0;
      if (f[i]) l[c - 2'h1] = 1'b1;
    end
    return {f, l, |l, l[2] ? 2'h2 : l[1] ? 2'h1 : 2'h0};
  endfunction
  task req(input logic [9:0] v);
    periph_req <= v;
    @(posedge hclk);
    pq.push_back(expo(v));
    ck_ph <= 1'b1;
    @(posedge hclk);
    ck_ph <= 1'b0;
  endtask
  // checks at the falling edge, where registered outputs have settled
  always @(negedge hclk) begin
    if (rd_ph) begin
      er = rq.pop_front();
      `CHK("hresp hrdata", {1'b0, er}, {hresp, hrdata})
    end
    if (ck_ph) begin
      ep = pq.pop_front();
      `CHK("requests", ep, {fwd_req, core_lvl_req, core_irq_valid, core_irq_level})
    end
  end
  initial begin
    {hresetn, hsel, hwrite, rd_ph, ck_ph} = '0;
    {haddr, htrans, hwdata, periph_req, r3, r4} = '0;
    hsize = 3'h2;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(32'hccbfb117));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, IPFD_REG_THREE_ADDR, 16'h0);
    xfer(1'b0, IPFD_REG_FOUR_ADDR, 16'h0);
    req(10'h3ff);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, IPFD_REG_THREE_ADDR, {8{2'(c)}});
      xfer(1'b1, IPFD_REG_FOUR_ADDR, {8{2'(c)}});
      xfer(1'b0, IPFD_REG_FOUR_ADDR, 16'h0);
      req(10'h3ff);
    end
    for (int k = 0; k < 40; k++) begin
      xfer(1'b1, k[0] ? IPFD_REG_FOUR_ADDR : IPFD_REG_THREE_ADDR, 16'($urandom));
      xfer(1'b0, k[0] ? IPFD_REG_FOUR_ADDR : IPFD_REG_THREE_ADDR, 16'h0);
      req(10'($urandom));
      req(10'(1 << ($urandom % 10)));
    end
    // unmapped word: write dropped, reads zero
    xfer(1'b1, 8'h14, 16'hffff);
    xfer(1'b0, 8'h14, 16'h0);
    xfer(1'b0, IPFD_REG_THREE_ADDR, 16'h0);
    xfer(1'b0, IPFD_REG_FOUR_ADDR, 16'h0);
    // a reset in mid-run must put every field back to disabled
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    r3 = 16'h0000;
    r4 = 16'h0000;
    xfer(1'b0, IPFD_REG_THREE_ADDR, 16'h0);
    xfer(1'b0, IPFD_REG_FOUR_ADDR, 16'h0);
    req(10'h3ff);
    close_out;
  end
endmodule // irq_priority_field_decode_tb_top
`default_nettype wire
